// ===== src/hm_countdown.sv
`timescale 1ns/1ps
`default_nettype none
module hm_countdown #(
    parameter int W = 32
) (
    // Clock and control
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    // Counter
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic dec,
    output logic zero
);
    logic [W-1:0] cnt_ff;

    assign zero = (cnt_ff == '0);

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cnt_ff <= '0;
        end else if (ce) begin
            if (load) cnt_ff <= load_val;
            else if (dec && !zero) cnt_ff <= cnt_ff - 1'b1;
        end
    end
endmodule : hm_countdown
`default_nettype wire

// ===== src/hm_decode.sv
`timescale 1ns/1ps
`default_nettype none
module hm_decode (
    // Clock and control
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    // Monitor link
    hm_mon_if.dec mon
);
    import hm_pkg::*;

    logic [11:0] vset_ff;
    logic valid_ff;
    logic pg_ff;
    wire [9:0] thr_pm = hm_thr_pm(mon.thr); // RQ3
    wire rail_low = hm_below(mon.rail, vset_ff, thr_pm); // RQ3

    assign mon.vset = vset_ff;
    assign mon.vset_valid = valid_ff;
    assign mon.pg = pg_ff;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            vset_ff <= VSET_MIN;
            valid_ff <= 1'b0;
            pg_ff <= 1'b0;
        end else if (ce) begin
            vset_ff <= hm_vset(mon.vcode); // RQ1
            valid_ff <= mon.trim_open; // RQ1
            pg_ff <= !rail_low; // RQ2
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn || !ce);

    AST_VSET_SAT: assert property (mon.vcode[4] && mon.vcode[3:0] >= 4'h7 |=> vset_ff == 12'haf0) // RQ1
        else $error("saturated voltage code not decoded to 28V");
    AST_PG_LOW: assert property ({12'h000, mon.rail} * 24'h0003e8 < {12'h000, vset_ff} * {14'h0000, thr_pm}
        |=> !pg_ff) // RQ2
        else $error("power good high while rail below threshold");
endmodule : hm_decode
`default_nettype wire

// ===== src/hm_mon_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hm_mon_if;
    logic [4:0] vcode;
    logic [3:0] thr;
    logic [11:0] rail;
    logic trim_open;
    logic [11:0] vset;
    logic vset_valid;
    logic pg;
    modport ctl (output vcode, thr, rail, trim_open, input vset, vset_valid, pg);
    modport dec (input vcode, thr, rail, trim_open, output vset, vset_valid, pg);
endinterface : hm_mon_if
`default_nettype wire

// ===== src/hm_pkg.sv
// Summary of operation
// RQ1: With trim pin open, decode 5-bit voltage code; upper codes saturate at 28V.
// RQ2: Storage power-good is high only while the rail is above the threshold.
// RQ3: One 4-bit threshold code, 95.0% to 98.0% in 0.2% steps, serves both uses.
// RQ4: A check sinks 10mA for the discharge time, then 50mA for 200us.
// RQ5: A droop beyond threshold sets the fault bit and pulls the interrupt low.
// RQ6: When discharge ends the boost converter is enabled again to recharge.
// RQ7: Checks run on their own, on host trigger, or only on host demand.
// RQ8: Autocheck disable bit 4 of register 0x0B stops periodic checks.
// RQ9: One-shot bit 1 of register 0x06 starts a check even when disabled.
// RQ10: With no scaling, periodic checks start every 4 minutes.
// RQ11: Scaling bits 1:0 of register 0x10 stretch the period to 8 or 16 minutes.
// RQ12: Manual sink bit 2 of register 0x06 turns the 10mA sink on; host turns it off.
// RQ13: During manual discharge the droop is still compared against the threshold.
// RQ14: Discharge code: 2ms doubling to 256ms, or 384ms to 1280ms in 128ms steps.
// RQ15: A one-shot arriving during a running check is absorbed by that check.
package hm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_HZ = 40000000;
    localparam int PULSE_US = 200;
    localparam int PULSE_CYC = PULSE_US * (CLK_HZ / 1000000);
    localparam int MS_CYC = CLK_HZ / 1000;
    localparam int PERIOD_MIN = 4;
    localparam int PERIOD_MS = PERIOD_MIN * 60 * 1000;
    localparam int TW = 32;

    ////////////////////////////////////////////////////////////////////////////
    // Register map: index, byte address is four times it
    localparam int AW = 10;
    localparam int DW = 8;
    localparam logic [7:0] IDX_TRIG = 8'h06;
    localparam logic [7:0] IDX_CHKCFG = 8'h0b;
    localparam logic [7:0] IDX_THR = 8'h0c;
    localparam logic [7:0] IDX_VSET = 8'h0d;
    localparam logic [7:0] IDX_SCALE = 8'h10;
    localparam logic [7:0] IDX_STATUS = 8'h20;
    localparam logic [7:0] IDX_MASK = 8'h21;
    localparam logic [7:0] IDX_STATE = 8'h22;
    localparam int TRIG_ONESHOT_BIT = 1;
    localparam int TRIG_MANUAL_BIT = 2;
    localparam int CFG_DIS_BIT = 4;
    localparam int ST_FAULT_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam logic [3:0] RST_TSET = 4'h4;
    localparam logic [3:0] RST_THR = 4'h0;
    localparam logic [4:0] RST_VCODE = 5'h17;
    localparam logic [1:0] RST_SCALE = 2'h0;
    localparam logic [1:0] RST_MASK = 2'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Decode constants; voltages in 10mV, threshold in 0.1%
    localparam logic [11:0] VSET_MIN = 12'h1f4;
    localparam logic [11:0] VSET_C1 = 12'h230;
    localparam logic [11:0] VSET_STEP = 12'h064;
    localparam logic [11:0] VSET_HI_BASE = 12'h834;
    localparam logic [11:0] VSET_MAX = 12'haf0;
    localparam logic [3:0] VSET_SAT_CODE = 4'h7;
    localparam logic [9:0] THR_BASE = 10'h3b6;
    localparam logic [23:0] PM_FULL = 24'h0003e8;
    localparam logic [10:0] TSET_LO_BASE = 11'h002;
    localparam logic [10:0] TSET_HI_BASE = 11'h180;
    localparam logic [10:0] TSET_HI_STEP = 11'h080;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SOAK = 2'b01,
        ST_PULSE = 2'b10,
        ST_RECHG = 2'b11
    } hm_state_t;

    function automatic logic hm_sel(input logic [AW-1:0] addr, input logic [7:0] idx);
        return (addr[1:0] == 2'h0) && (addr[AW-1:2] == idx);
    endfunction : hm_sel

    function automatic logic [11:0] hm_vset(input logic [4:0] code);
        logic [11:0] v;
        v = VSET_MIN;
        if (code[4]) begin
            if (code[3:0] >= VSET_SAT_CODE) v = VSET_MAX;
            else v = 12'(VSET_HI_BASE + VSET_STEP * {8'h00, code[3:0]});
        end else if (code[3:0] == 4'h1) begin
            v = VSET_C1;
        end else if (code[3:0] != 4'h0) begin
            v = 12'(({8'h00, code[3:0]} + 12'h005) * VSET_STEP);
        end
        return v;
    endfunction : hm_vset

    function automatic logic [9:0] hm_thr_pm(input logic [3:0] code);
        return 10'(THR_BASE + {5'h00, code, 1'b0});
    endfunction : hm_thr_pm

    // True when v sits below thr per mille of ref
    function automatic logic hm_below(input logic [11:0] v, input logic [11:0] ref_v, input logic [9:0] thr);
        logic [23:0] a;
        logic [23:0] b;
        a = {12'h000, v} * PM_FULL;
        b = {12'h000, ref_v} * {14'h0000, thr};
        return a < b;
    endfunction : hm_below

    function automatic logic [10:0] hm_tset_ms(input logic [3:0] code);
        if (code[3]) return 11'(TSET_HI_BASE + TSET_HI_STEP * {8'h00, code[2:0]});
        return 11'(TSET_LO_BASE << code[2:0]);
    endfunction : hm_tset_ms

endpackage : hm_pkg

// ===== src/hm_top.sv
`timescale 1ns/1ps
`default_nettype none
module hm_top
    import hm_pkg::*;
#(
    parameter int P_MS_CYC = hm_pkg::MS_CYC,
    parameter int P_PULSE_CYC = hm_pkg::PULSE_CYC,
    parameter int P_PERIOD_MS = hm_pkg::PERIOD_MS
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    // Register port
    input wire logic [hm_pkg::AW-1:0] reg_addr,
    input wire logic [hm_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [hm_pkg::DW-1:0] reg_rdata_ff,
    // Storage rail sense
    input wire logic [11:0] storage_rail,
    input wire logic storage_trim_resistor_pin_open,
    // Power stage controls
    output logic sink_10ma_en_ff,
    output logic sink_50ma_en_ff,
    output logic boost_enable_ff,
    // Indications
    output logic storage_power_good,
    output logic [11:0] storage_voltage_setting,
    output logic storage_voltage_valid,
    output logic interrupt_request_n_ff
);
    import hm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic manual_sink_enable_ff;
    logic autocheck_disable_ff;
    logic [3:0] discharge_time_code_ff;
    logic [3:0] droop_threshold_code_ff;
    logic [4:0] storage_voltage_code_ff;
    logic check_period_double_ff;
    logic check_period_quadruple_ff;
    logic [1:0] stat_ff;
    logic [1:0] mask_ff;
    hm_state_t state_ff;
    hm_state_t nxt_state;
    logic [11:0] ref_ff;
    logic [DW-1:0] nxt_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    wire wr_trig = reg_wr && hm_sel(reg_addr, IDX_TRIG);
    wire wr_cfg = reg_wr && hm_sel(reg_addr, IDX_CHKCFG);
    wire wr_thr = reg_wr && hm_sel(reg_addr, IDX_THR);
    wire wr_vset = reg_wr && hm_sel(reg_addr, IDX_VSET);
    wire wr_scale = reg_wr && hm_sel(reg_addr, IDX_SCALE);
    wire wr_status = reg_wr && hm_sel(reg_addr, IDX_STATUS);
    wire wr_mask = reg_wr && hm_sel(reg_addr, IDX_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // Check control
    wire oneshot_check_trigger = wr_trig && reg_wdata[TRIG_ONESHOT_BIT]; // RQ9
    wire nxt_manual = wr_trig ? reg_wdata[TRIG_MANUAL_BIT] : manual_sink_enable_ff; // RQ12
    wire manual_rise = nxt_manual && !manual_sink_enable_ff;
    wire ms_tick;
    wire phase_zero;
    wire period_zero;
    // Only a free sequencer starts; a trigger during a check is absorbed
    wire seq_free = (state_ff == ST_IDLE) && !manual_sink_enable_ff; // RQ15
    wire auto_req = period_zero && !autocheck_disable_ff; // RQ8 RQ10
    wire start_chk = seq_free && (oneshot_check_trigger || auto_req); // RQ7 RQ9
    wire in_soak = (state_ff == ST_SOAK);
    wire in_pulse = (state_ff == ST_PULSE);
    wire [9:0] thr_pm = hm_thr_pm(droop_threshold_code_ff); // RQ3
    wire [10:0] tset_ms = hm_tset_ms(discharge_time_code_ff); // RQ14
    wire droop_low = hm_below(storage_rail, ref_ff, thr_pm); // RQ5 RQ13
    wire monitoring = in_soak || in_pulse || manual_sink_enable_ff; // RQ13
    wire fault_evt = monitoring && droop_low; // RQ5
    wire done_evt = (state_ff == ST_RECHG);
    wire [1:0] per_shift = check_period_quadruple_ff ? 2'h2 : {1'b0, check_period_double_ff}; // RQ11
    wire [TW-1:0] period_val = TW'((P_PERIOD_MS << per_shift) - 1); // RQ10 RQ11
    wire [TW-1:0] phase_val = start_chk ? {{(TW-11){1'b0}}, tset_ms} : TW'(P_PULSE_CYC - 1); // RQ4 RQ14
    wire [1:0] clr_bits = wr_status ? reg_wdata[1:0] : 2'h0;
    // Set wins over a clear in the same cycle
    wire [1:0] nxt_stat = (stat_ff & ~clr_bits) | {done_evt, fault_evt}; // RQ5
    wire [1:0] nxt_mask = wr_mask ? reg_wdata[1:0] : mask_ff;
    wire nxt_discharge = (nxt_state == ST_SOAK) || (nxt_state == ST_PULSE);

    ////////////////////////////////////////////////////////////////////////////
    // Timers; the millisecond prescaler restarts with each check so soak is exact
    hm_countdown #(.W(TW)) u_prescale (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .load(ms_tick || start_chk),
        .load_val(TW'(P_MS_CYC - 1)),
        .dec(1'b1),
        .zero(ms_tick)
    );

    hm_countdown #(.W(TW)) u_phase (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .load(start_chk || (in_soak && phase_zero)),
        .load_val(phase_val),
        .dec(in_soak ? ms_tick : in_pulse),
        .zero(phase_zero)
    ); // RQ4 RQ14

    hm_countdown #(.W(TW)) u_period (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .load(period_zero),
        .load_val(period_val),
        .dec(ms_tick),
        .zero(period_zero)
    ); // RQ10 RQ11

    ////////////////////////////////////////////////////////////////////////////
    // Threshold and voltage decode
    hm_mon_if mon ();
    assign mon.vcode = storage_voltage_code_ff;
    assign mon.thr = droop_threshold_code_ff;
    assign mon.rail = storage_rail;
    assign mon.trim_open = storage_trim_resistor_pin_open;
    assign storage_voltage_setting = mon.vset; // RQ1
    assign storage_voltage_valid = mon.vset_valid; // RQ1
    assign storage_power_good = mon.pg; // RQ2

    hm_decode u_decode (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .mon(mon.dec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (start_chk) nxt_state = ST_SOAK; // RQ4
            end
            ST_SOAK: begin
                if (phase_zero) nxt_state = ST_PULSE; // RQ4
            end
            ST_PULSE: begin
                if (phase_zero) nxt_state = ST_RECHG; // RQ6
            end
            ST_RECHG: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
            ref_ff <= 12'h000;
            sink_10ma_en_ff <= 1'b0;
            sink_50ma_en_ff <= 1'b0;
            boost_enable_ff <= 1'b1;
        end else if (ce) begin
            state_ff <= nxt_state;
            // Droop is judged against the rail at the start of discharge
            if (start_chk || manual_rise) ref_ff <= storage_rail; // RQ13
            sink_10ma_en_ff <= (nxt_state == ST_SOAK) || nxt_manual; // RQ4 RQ12
            sink_50ma_en_ff <= (nxt_state == ST_PULSE); // RQ4
            // Boost would mask the droop, so it stays off until discharge ends
            boost_enable_ff <= !nxt_discharge && !nxt_manual; // RQ6
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file and interrupt
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            manual_sink_enable_ff <= 1'b0;
            autocheck_disable_ff <= 1'b0;
            discharge_time_code_ff <= RST_TSET;
            droop_threshold_code_ff <= RST_THR;
            storage_voltage_code_ff <= RST_VCODE;
            check_period_double_ff <= RST_SCALE[0];
            check_period_quadruple_ff <= RST_SCALE[1];
            stat_ff <= 2'h0;
            mask_ff <= RST_MASK;
            interrupt_request_n_ff <= 1'b1;
            reg_rdata_ff <= '0;
        end else if (ce) begin
            manual_sink_enable_ff <= nxt_manual; // RQ12
            if (wr_cfg) begin
                autocheck_disable_ff <= reg_wdata[CFG_DIS_BIT]; // RQ8
                discharge_time_code_ff <= reg_wdata[3:0]; // RQ14
            end
            if (wr_thr) droop_threshold_code_ff <= reg_wdata[3:0]; // RQ3
            if (wr_vset) storage_voltage_code_ff <= reg_wdata[4:0]; // RQ1
            if (wr_scale) begin
                check_period_double_ff <= reg_wdata[0]; // RQ11
                check_period_quadruple_ff <= reg_wdata[1]; // RQ11
            end
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            interrupt_request_n_ff <= ~|(nxt_stat & nxt_mask); // RQ5
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // Read data stand for one cycle only; unmapped reads return zero
    always_comb begin
        nxt_rdata = '0;
        if (reg_rd && reg_addr[1:0] == 2'h0) begin
            case (reg_addr[AW-1:2])
                IDX_TRIG: nxt_rdata = DW'({manual_sink_enable_ff, 2'h0});
                IDX_CHKCFG: nxt_rdata = DW'({autocheck_disable_ff, discharge_time_code_ff});
                IDX_THR: nxt_rdata = DW'(droop_threshold_code_ff);
                IDX_VSET: nxt_rdata = DW'(storage_voltage_code_ff);
                IDX_SCALE: nxt_rdata = DW'({check_period_quadruple_ff, check_period_double_ff});
                IDX_STATUS: nxt_rdata = DW'(stat_ff);
                IDX_MASK: nxt_rdata = DW'(mask_ff);
                IDX_STATE: nxt_rdata = DW'({droop_low, mon.pg, state_ff});
                default: nxt_rdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [TW-1:0] soak_ms_cnt;
    logic [TW-1:0] pulse_cyc_cnt;
    logic [10:0] chk_tset;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            soak_ms_cnt <= '0;
            pulse_cyc_cnt <= '0;
            chk_tset <= 11'h000;
        end else if (ce) begin
            if (start_chk) chk_tset <= tset_ms;
            if (!in_soak) soak_ms_cnt <= '0;
            else if (ms_tick) soak_ms_cnt <= soak_ms_cnt + 1'b1;
            if (!in_pulse) pulse_cyc_cnt <= '0;
            else pulse_cyc_cnt <= pulse_cyc_cnt + 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn || !ce);

    sequence s_soak_exit;
        in_soak ##1 in_pulse;
    endsequence

    sequence s_pulse_exit;
        in_pulse ##1 (state_ff == ST_RECHG);
    endsequence

    AST_THR_RANGE: assert property (thr_pm >= 10'h3b6 && thr_pm <= 10'h3d4) // RQ3
        else $error("threshold outside 95.0 to 98.0 percent");
    AST_SOAK_LEN: assert property (s_soak_exit |-> {21'h0, chk_tset} == $past(soak_ms_cnt)
        + {31'h0, $past(ms_tick)}) // RQ14
        else $error("soak length differs from discharge time code");
    AST_SOAK_SINKS: assert property (in_soak |-> sink_10ma_en_ff && !sink_50ma_en_ff && !boost_enable_ff) // RQ4
        else $error("wrong sinks during soak");
    AST_PULSE_LEN: assert property (s_pulse_exit |-> $past(pulse_cyc_cnt) == TW'(P_PULSE_CYC - 1)) // RQ4
        else $error("50mA pulse length wrong");
    AST_FAULT_IRQ: assert property (fault_evt && mask_ff[0] && !wr_mask |=> !interrupt_request_n_ff
        && stat_ff[ST_FAULT_BIT]) // RQ5 RQ13
        else $error("droop fault did not raise interrupt");
    AST_RECHARGE: assert property (s_pulse_exit |-> boost_enable_ff ##1 !sink_50ma_en_ff) // RQ6
        else $error("boost not re-enabled after discharge");
    AST_DISABLED: assert property (seq_free && autocheck_disable_ff && !oneshot_check_trigger |=> !in_soak) // RQ8
        else $error("autonomous check ran while disabled");
    AST_ONESHOT: assert property (seq_free && oneshot_check_trigger |=> in_soak ##1 in_soak) // RQ9
        else $error("one-shot trigger did not start a check");
    AST_NO_REQUEUE: assert property (in_pulse && oneshot_check_trigger |=> !in_soak [*2]) // RQ15
        else $error("one-shot during a check was queued");
    AST_MANUAL: assert property ($rose(manual_sink_enable_ff) |-> sink_10ma_en_ff && ref_ff == $past(storage_rail)) // RQ12
        else $error("manual sink not applied");
endmodule : hm_top
`default_nettype wire

// ===== verification/hm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hm_host_model (
    // Register port
    input wire logic clk_sys,
    output logic [hm_pkg::AW-1:0] reg_addr,
    output logic [hm_pkg::DW-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [hm_pkg::DW-1:0] reg_rdata_ff
);
    import hm_pkg::*;
    initial begin
        reg_addr = 10'h000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    // Data stands only in the cycle after the strobe, so it is taken just past that edge
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_ff;
    endtask : rd
    // In manual mode nothing ends the discharge but the host itself
    task automatic manual(input logic on);
        wr(10'h018, {5'h00, on, 2'h0});
    endtask : manual
endmodule : hm_host_model
`default_nettype wire

// ===== verification/storage_cap_health_monitor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module storage_cap_health_monitor_tb_top;
    import hm_pkg::*;
    localparam int MSC = 4;
    localparam int PLS = 5;
    localparam int PER = 50;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic trim = 1'b1;
    logic ce = 1'b1;
    logic [11:0] rail = 12'h3e8;
    logic [11:0] ref_v, lo, hi;
    logic [31:0] lfsr_st = 32'hed90a7c8;
    logic [31:0] r;
    logic [3:0] tcs [4] = '{4'h0, 4'h3, 4'h7, 4'h8};
    wire logic [9:0] addr;
    wire logic [7:0] wdata, rdata;
    wire logic wr, rd, s10, s50, boost, pg, vval, irq_n;
    wire logic [11:0] vset;
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0, n_start = 0, t_start = 0, t_prev = 0, n10 = 0, n50 = 0;
    int k, c, j, th, e;
    logic s10_q = 1'b0;

    always #12.5 clk_sys = ~clk_sys;

    hm_top #(.P_MS_CYC(MSC), .P_PULSE_CYC(PLS), .P_PERIOD_MS(PER)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata_ff(rdata),
        .storage_rail(rail), .storage_trim_resistor_pin_open(trim),
        .sink_10ma_en_ff(s10), .sink_50ma_en_ff(s50), .boost_enable_ff(boost),
        .storage_power_good(pg), .storage_voltage_setting(vset), .storage_voltage_valid(vval),
        .interrupt_request_n_ff(irq_n)
    );
    hm_host_model host (.clk_sys(clk_sys), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata_ff(rdata));

    ////////////////////////////////////////////////////////////////////////////
    // Counting on the falling edge keeps clear of the register updates
    always @(negedge clk_sys) begin
        cyc++;
        if (s10 === 1'b1 && s10_q !== 1'b1) begin
            n_start++;
            t_prev = t_start;
            t_start = cyc;
        end
        s10_q = s10;
        n10 += (s10 === 1'b1);
        n50 += (s50 === 1'b1);
    end

    function automatic logic [31:0] rnd();
        lfsr_st = {lfsr_st[30:0], lfsr_st[31] ^ lfsr_st[21] ^ lfsr_st[1] ^ lfsr_st[0]};
        return lfsr_st;
    endfunction : rnd
    function automatic int vexp(input logic [4:0] v);
        if (v[4]) return (v[3:0] >= 4'h7) ? 2800 : 2100 + 100 * v[3:0];
        if (v[3:0] < 4'h2) return v[0] ? 560 : 500;
        return 100 * (v[3:0] + 5);
    endfunction : vexp
    function automatic int soak(input logic [3:0] t);
        return (t[3] ? 384 + 128 * t[2:0] : 2 << t[2:0]) * MSC + 1;
    endfunction : soak
    // Equality is never hit: one step either side of the threshold
    function automatic void limits(input logic [3:0] t);
        th = ref_v * (950 + 2 * t) / 1000;
        lo = 12'(th - 1);
        hi = 12'(th + 1);
    endfunction : limits

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_reg(input logic [9:0] a, input logic [7:0] x);
        logic [7:0] v;
        host.rd(a, v);
        chk(v, x);
    endtask : chk_reg
    task automatic end_of_test();
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    task automatic run_check(input logic [3:0] tc, input logic [11:0] drop, input bit twice);
        int i = 0;
        int k0;
        rail <= ref_v;
        host.wr(10'h02c, {4'h1, tc});
        k0 = n_start;
        n10 = 0;
        n50 = 0;
        host.wr(10'h018, 8'h02);
        #1;
        chk(s10, 1);
        chk(boost, 0);
        if (twice) host.wr(10'h018, 8'h02);
        while (s50 !== 1'b1 && i < 4000) begin
            @(posedge clk_sys);
            #1;
            i++;
        end
        // A second trigger inside the pulse must be absorbed as well
        if (twice) host.wr(10'h018, 8'h02);
        @(posedge clk_sys);
        rail <= drop;
        while ((s10 | s50) !== 1'b0 && i < 8000) begin
            @(posedge clk_sys);
            #1;
            i++;
        end
        repeat (3) @(posedge clk_sys);
        chk(n_start - k0, 1);
        chk(n10, soak(tc));
        chk(n50, PLS);
        chk(boost, 1);
    endtask : run_check

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        chk_reg(10'h02c, 8'h04);
        chk_reg(10'h030, 8'h00);
        chk_reg(10'h034, 8'h17);
        chk_reg(10'h040, 8'h00);
        chk_reg(10'h084, 8'h01);
        chk_reg(10'h3fc, 8'h00);
        host.wr(10'h02c, 8'h10);
        repeat (200) @(posedge clk_sys);
        host.wr(10'h080, 8'h03);
        k = n_start;
        repeat (450) @(posedge clk_sys);
        chk(n_start - k, 0);
        // A write while the enable is low must not land
        ce <= 1'b0;
        host.wr(10'h030, 8'h05);
        ce <= 1'b1;
        chk_reg(10'h030, 8'h00);
        $display("reset and disable done");
        for (c = 0; c < 32; c++) begin
            trim <= c[0];
            host.wr(10'h034, 8'(c));
            repeat (3) @(posedge clk_sys);
            chk(vset, vexp(5'(c)));
            chk(vval, c[0]);
        end
        ref_v = 12'(vexp(5'h1f));
        for (c = 0; c < 16; c++) begin
            limits(4'(c));
            host.wr(10'h030, 8'(c));
            rail <= lo;
            repeat (4) @(posedge clk_sys);
            chk(pg, 0);
            rail <= hi;
            repeat (4) @(posedge clk_sys);
            chk(pg, 1);
        end
        $display("decode and power good done");
        for (j = 0; j < 4; j++) begin
            r = rnd();
            ref_v = 12'h3e8 + {2'h0, r[15:8], 2'h0};
            limits(r[3:0]);
            host.wr(10'h030, {4'h0, r[3:0]});
            run_check(tcs[j], j[0] ? lo : hi, j == 1);
            chk_reg(10'h080, {6'h00, 1'b1, j[0]});
            chk(irq_n, !j[0]);
            host.wr(10'h080, 8'h03);
            chk_reg(10'h080, 8'h00);
        end
        $display("triggered checks done");
        host.wr(10'h084, 8'h00);
        rail <= ref_v;
        host.manual(1'b1);
        #1;
        chk(s10, 1);
        chk(boost, 0);
        chk_reg(10'h018, 8'h04);
        @(posedge clk_sys);
        rail <= lo;
        repeat (4) @(posedge clk_sys);
        chk_reg(10'h080, 8'h01);
        chk_reg(10'h088, 8'h08);
        chk(irq_n, 1);
        host.wr(10'h084, 8'h01);
        repeat (2) @(posedge clk_sys);
        chk(irq_n, 0);
        host.manual(1'b0);
        rail <= ref_v;
        repeat (2) @(posedge clk_sys);
        chk(s10, 0);
        chk(boost, 1);
        host.wr(10'h080, 8'h03);
        repeat (2) @(posedge clk_sys);
        chk(irq_n, 1);
        $display("manual discharge done");
        host.wr(10'h02c, 8'h00);
        for (j = 0; j < 4; j++) begin
            host.wr(10'h040, 8'(j));
            k = n_start;
            c = 0;
            while (n_start < k + 3 && c < 9000) begin
                @(posedge clk_sys);
                c++;
            end
            e = PER * MSC * (j[1] ? 4 : (j[0] ? 2 : 1));
            chk((t_start - t_prev >= e - 8) && (t_start - t_prev <= e + 8), 1);
        end
        $display("periodic checks done");
        end_of_test();
    end

    // Whole run is near 10000 cycles; a hang is cut well beyond that
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        end_of_test();
    end
endmodule : storage_cap_health_monitor_tb_top
`default_nettype wire
